/* nibble_alu_pkg.sv */
// Shared constants for the nibble ALU status-flag block
package nibble_alu_pkg;

    // ------------------------------------------------------------
    // Register byte addresses on the APB
    // ------------------------------------------------------------
    localparam logic [7:0] status_word_addr = 8'h00;
    localparam logic [7:0] instr_addr       = 8'h04;
    localparam logic [7:0] result_addr      = 8'h08;
    localparam logic [7:0] temp_addr        = 8'h0c;

    // ------------------------------------------------------------
    // Status word field positions and reset value
    // ------------------------------------------------------------
    localparam int zero_bit      = 0;
    localparam int carry_bit     = 1;
    localparam int cmp_hold_bit  = 2;
    localparam int dec_adj_bit   = 3;
    localparam logic [3:0] status_word_reset = 4'h0;

    // ------------------------------------------------------------
    // Instruction register fields
    // ------------------------------------------------------------
    localparam int opcode_lsb  = 0;
    localparam int first_lsb   = 4;
    localparam int second_lsb  = 8;
    localparam logic [11:0] instr_reset = 12'h000;

    // ------------------------------------------------------------
    // Result register fields
    // ------------------------------------------------------------
    localparam int res_wb_bit   = 4;
    localparam int res_skip_bit = 5;
    localparam int res_busy_bit = 6;
    localparam int res_bad_bit  = 7;

    // ------------------------------------------------------------
    // Opcode encodings
    // ------------------------------------------------------------
    localparam logic [3:0] op_add        = 4'h0;
    localparam logic [3:0] op_add_carry  = 4'h1;
    localparam logic [3:0] op_sub        = 4'h2;
    localparam logic [3:0] op_sub_borrow = 4'h3;
    localparam logic [3:0] op_or         = 4'h4;
    localparam logic [3:0] op_and        = 4'h5;
    localparam logic [3:0] op_xor        = 4'h6;
    localparam logic [3:0] op_test_true  = 4'h7;
    localparam logic [3:0] op_test_false = 4'h8;
    localparam logic [3:0] op_cmp_eq     = 4'h9;
    localparam logic [3:0] op_cmp_ne     = 4'ha;
    localparam logic [3:0] op_cmp_ge     = 4'hb;
    localparam logic [3:0] op_cmp_lt     = 4'hc;
    localparam logic [3:0] op_rotate     = 4'hd;

    // Decimal correction thresholds
    localparam logic [4:0] dec_ten = 5'h0a;
    localparam logic [4:0] dec_twenty = 5'h14;

endpackage

/* operand_latch.sv */
// Temporary operand registers A and B
`timescale 1ns/1ns
module operand_latch (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Load request and operands
    input  wire logic       load,
    input  wire logic [3:0] first_in,
    input  wire logic [3:0] second_in,
    // Held operands
    output logic [3:0]      tmp_a_reg,
    output logic [3:0]      tmp_b_reg
);

    // Both operands are captured together so the ALU never mixes instructions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmp_a_reg <= 4'h0;
            tmp_b_reg <= 4'h0;
        end else if (load) begin
            tmp_a_reg <= first_in;
            tmp_b_reg <= second_in;
        end
    end

endmodule

/* decimal_correct.sv */
// Decimal correction of a nibble add or subtract result
`timescale 1ns/1ns
module decimal_correct (
    // Raw binary outcome
    input  wire logic       is_sub,
    input  wire logic       bin_carry,
    input  wire logic [3:0] bin_nibble,
    // Corrected outcome
    output logic [3:0]      dec_nibble,
    output logic            dec_carry
);

    logic [4:0] sum5;

    // Out-of-range sums land on 1010B or above so software can spot them
    always_comb begin
        sum5       = {bin_carry, bin_nibble};
        dec_nibble = bin_nibble;
        dec_carry  = bin_carry;
        if (!is_sub) begin
            dec_carry = (sum5 >= nibble_alu_pkg::dec_ten);
            if (sum5 < nibble_alu_pkg::dec_ten) begin
                dec_nibble = bin_nibble;
            end else if (sum5 < nibble_alu_pkg::dec_twenty) begin
                dec_nibble = bin_nibble + 4'h6;
            end else begin
                case (sum5[3:0])
                    4'h4, 4'h8:  dec_nibble = 4'he;
                    4'h5, 4'h9:  dec_nibble = 4'hf;
                    4'h6, 4'ha:  dec_nibble = 4'hc;
                    4'h7, 4'hb:  dec_nibble = 4'hd;
                    4'hc:        dec_nibble = 4'ha;
                    4'hd:        dec_nibble = 4'hb;
                    4'he:        dec_nibble = 4'hc;
                    default:     dec_nibble = 4'hd;
                endcase
            end
        end else begin
            dec_carry = bin_carry | (bin_nibble >= 4'ha);
            if (!bin_carry) begin
                if (bin_nibble >= 4'ha) begin
                    dec_nibble = {2'b11, bin_nibble[1:0] + 2'h2};
                end
            end else if (bin_nibble >= 4'h6) begin
                dec_nibble = bin_nibble - 4'h6;
            end else begin
                dec_nibble = {2'b11, bin_nibble[1:0] + 2'h2};
            end
        end
    end

endmodule

/* nibble_alu.sv */
// Nibble ALU with status flip-flop, APB register access and sequencer outputs
//
// How it works
// - compare hold suppresses arithmetic result write-back
// - decimal flag corrects every arithmetic result
// - decimal flag clear gives plain binary
// - arithmetic sets carry on carry or borrow
// - hold clear: zero flag follows result
// - hold set: zero result keeps flag
// - carry-in instructions feed carry flag
// - rotate right moves carry through bit three
// - only arithmetic and rotate change carry
// - bit tests clear compare hold
// - compare hold ignored outside arithmetic
// - decimal flag ignored outside arithmetic
// - status word and ALU flags share storage
// - operands latched into temporaries first
// - logic ops leave zero and carry alone
// - decimal overflow stores 1010B or higher
// - compares only decide skip, bit tests also clear hold
`timescale 1ns/1ns
module nibble_alu (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Sequencer side
    output logic [3:0]       result_data,
    output logic             result_write,
    output logic             skip_next,
    output logic             alu_busy,
    output logic [3:0]       status_flags
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef enum logic [0:0] {st_idle, st_exec} state_t;

    state_t      state_reg;
    logic [3:0]  psw_reg;
    logic [3:0]  psw_next;
    logic [11:0] instr_reg;
    logic [3:0]  op_reg;
    logic [3:0]  result_reg;
    logic [3:0]  result_next;
    logic        wb_reg;
    logic        wb_next;
    logic        skip_reg;
    logic        skip_next_val;
    logic        bad_reg;
    logic        bad_next;
    logic [31:0] prdata_reg;
    logic [3:0]  tmp_a;
    logic [3:0]  tmp_b;
    logic        setup_phase;
    logic        access_phase;
    logic        addr_ok;
    logic        wr_psw;
    logic        wr_instr;
    logic        instr_refused;
    logic        load_ops;
    logic        is_arith;
    logic        is_sub;
    logic        use_carry;
    logic [4:0]  bin_full;
    logic [3:0]  dec_nibble;
    logic        dec_carry;
    logic [3:0]  arith_nibble;
    logic        arith_carry;
    logic [4:0]  cmp_diff;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Recognised register addresses
    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == nibble_alu_pkg::status_word_addr) ||
                     (a == nibble_alu_pkg::instr_addr) ||
                     (a == nibble_alu_pkg::result_addr) ||
                     (a == nibble_alu_pkg::temp_addr);
    endfunction

    // Five-bit subtract shared by arithmetic and comparison
    function automatic logic [4:0] nib_sub(input logic [3:0] a,
                                           input logic [3:0] b,
                                           input logic       bin);
        nib_sub = {1'b0, a} - {1'b0, b} - {4'h0, bin};
    endfunction

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Zero wait states: read data is fetched during the setup cycle
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign addr_ok      = addr_known(paddr);
    assign pready       = 1'b1;
    assign prdata       = prdata_reg;

    // Instruction issue is refused while the previous one is executing
    assign instr_refused = (state_reg == st_exec) && (paddr == nibble_alu_pkg::instr_addr)
                           && pwrite;
    assign pslverr = access_phase && (!addr_ok || instr_refused);

    assign wr_psw   = access_phase && pwrite && (paddr == nibble_alu_pkg::status_word_addr);
    assign wr_instr = access_phase && pwrite && (paddr == nibble_alu_pkg::instr_addr)
                      && !instr_refused;
    assign load_ops = wr_instr;

    // Read data register, loaded in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            case (paddr)
                nibble_alu_pkg::status_word_addr: prdata_reg <= {28'h0, psw_reg};
                nibble_alu_pkg::instr_addr:       prdata_reg <= {20'h0, instr_reg};
                nibble_alu_pkg::result_addr: begin
                    prdata_reg <= {24'h0, bad_reg, (state_reg == st_exec), skip_reg,
                                   wb_reg, result_reg};
                end
                nibble_alu_pkg::temp_addr:        prdata_reg <= {24'h0, tmp_b, tmp_a};
                default:                          prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Instruction register and sequencing
    // ------------------------------------------------------------
    // Written value is kept so software can read back what it issued
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_reg <= nibble_alu_pkg::instr_reset;
            op_reg    <= 4'h0;
        end else if (wr_instr) begin
            instr_reg <= pwdata[11:0];
            op_reg    <= pwdata[nibble_alu_pkg::opcode_lsb +: 4];
        end
    end

    // One latch cycle, one execute cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= st_idle;
        end else begin
            case (state_reg)
                st_idle: begin
                    if (wr_instr) begin
                        state_reg <= st_exec;
                    end
                end
                st_exec: state_reg <= st_idle;
                default: state_reg <= st_idle;
            endcase
        end
    end

    // Operands go to the temporaries before the ALU looks at them
    operand_latch u_operands (
        .pclk      (pclk),
        .presetn   (presetn),
        .load      (load_ops),
        .first_in  (pwdata[nibble_alu_pkg::first_lsb +: 4]),
        .second_in (pwdata[nibble_alu_pkg::second_lsb +: 4]),
        .tmp_a_reg (tmp_a),
        .tmp_b_reg (tmp_b)
    );

    // ------------------------------------------------------------
    // Arithmetic datapath
    // ------------------------------------------------------------
    assign is_arith  = (op_reg == nibble_alu_pkg::op_add) ||
                       (op_reg == nibble_alu_pkg::op_add_carry) ||
                       (op_reg == nibble_alu_pkg::op_sub) ||
                       (op_reg == nibble_alu_pkg::op_sub_borrow);
    assign is_sub    = (op_reg == nibble_alu_pkg::op_sub) ||
                       (op_reg == nibble_alu_pkg::op_sub_borrow);
    assign use_carry = (op_reg == nibble_alu_pkg::op_add_carry) ||
                       (op_reg == nibble_alu_pkg::op_sub_borrow);

    // Carry flag enters as the least significant carry or borrow
    always_comb begin
        if (is_sub) begin
            bin_full = nib_sub(tmp_a, tmp_b,
                               use_carry & psw_reg[nibble_alu_pkg::carry_bit]);
        end else begin
            bin_full = {1'b0, tmp_a} + {1'b0, tmp_b} +
                       {4'h0, use_carry & psw_reg[nibble_alu_pkg::carry_bit]};
        end
    end

    decimal_correct u_decimal (
        .is_sub     (is_sub),
        .bin_carry  (bin_full[4]),
        .bin_nibble (bin_full[3:0]),
        .dec_nibble (dec_nibble),
        .dec_carry  (dec_carry)
    );

    // Decimal correction only when the flag asks; otherwise plain binary
    always_comb begin
        if (psw_reg[nibble_alu_pkg::dec_adj_bit]) begin
            arith_nibble = dec_nibble;
            arith_carry  = dec_carry;
        end else begin
            arith_nibble = bin_full[3:0];
            arith_carry  = bin_full[4];
        end
    end

    // Comparisons always run in binary, whatever the mode flags say
    assign cmp_diff = nib_sub(tmp_b, 4'h0, 1'b0) == 5'h00 ? nib_sub(tmp_a, tmp_b, 1'b0)
                                                          : nib_sub(tmp_a, tmp_b, 1'b0);

    // ------------------------------------------------------------
    // Execute: flags, result and skip decision
    // ------------------------------------------------------------
    always_comb begin
        psw_next      = psw_reg;
        result_next   = result_reg;
        wb_next       = 1'b0;
        skip_next_val = 1'b0;
        bad_next      = 1'b0;
        // Software writes land in the same flags the ALU uses
        if (wr_psw) begin
            psw_next = pwdata[3:0];
        end
        // Execution updates win over a software write in the same cycle
        if (state_reg == st_exec) begin
            case (op_reg)
                nibble_alu_pkg::op_add,
                nibble_alu_pkg::op_add_carry,
                nibble_alu_pkg::op_sub,
                nibble_alu_pkg::op_sub_borrow: begin
                    result_next = arith_nibble;
                    psw_next[nibble_alu_pkg::carry_bit] = arith_carry;
                    if (!psw_reg[nibble_alu_pkg::cmp_hold_bit]) begin
                        psw_next[nibble_alu_pkg::zero_bit] = (arith_nibble == 4'h0);
                        wb_next = 1'b1;
                    end else begin
                        // Chained compares: zero survives only while every nibble is zero
                        psw_next[nibble_alu_pkg::zero_bit] =
                            (arith_nibble == 4'h0) & psw_reg[nibble_alu_pkg::zero_bit];
                        wb_next = 1'b0;
                    end
                end
                nibble_alu_pkg::op_or: begin
                    result_next = tmp_a | tmp_b;
                    wb_next     = 1'b1;
                end
                nibble_alu_pkg::op_and: begin
                    result_next = tmp_a & tmp_b;
                    wb_next     = 1'b1;
                end
                nibble_alu_pkg::op_xor: begin
                    result_next = tmp_a ^ tmp_b;
                    wb_next     = 1'b1;
                end
                nibble_alu_pkg::op_test_true: begin
                    psw_next[nibble_alu_pkg::cmp_hold_bit] = 1'b0;
                    skip_next_val = ((tmp_a & tmp_b) == tmp_b);
                end
                nibble_alu_pkg::op_test_false: begin
                    psw_next[nibble_alu_pkg::cmp_hold_bit] = 1'b0;
                    skip_next_val = ((tmp_a & tmp_b) == 4'h0);
                end
                nibble_alu_pkg::op_cmp_eq: begin
                    skip_next_val = (cmp_diff[3:0] == 4'h0);
                end
                nibble_alu_pkg::op_cmp_ne: begin
                    skip_next_val = (cmp_diff[3:0] != 4'h0);
                end
                nibble_alu_pkg::op_cmp_ge: begin
                    skip_next_val = !cmp_diff[4];
                end
                nibble_alu_pkg::op_cmp_lt: begin
                    skip_next_val = cmp_diff[4];
                end
                nibble_alu_pkg::op_rotate: begin
                    result_next = {psw_reg[nibble_alu_pkg::carry_bit], tmp_a[3:1]};
                    psw_next[nibble_alu_pkg::carry_bit] = tmp_a[0];
                    wb_next = 1'b1;
                end
                default: begin
                    // Unknown opcodes touch nothing and are reported
                    bad_next = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status flip-flop, shared with the program status word
    // ------------------------------------------------------------
    // One storage element: no copy can drift from what software sees
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psw_reg <= nibble_alu_pkg::status_word_reset;
        end else begin
            psw_reg <= psw_next;
        end
    end

    // Result nibble and its qualifiers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= 4'h0;
            wb_reg     <= 1'b0;
            skip_reg   <= 1'b0;
            bad_reg    <= 1'b0;
        end else if (state_reg == st_exec) begin
            result_reg <= result_next;
            wb_reg     <= wb_next;
            skip_reg   <= skip_next_val;
            bad_reg    <= bad_next;
        end
    end

    // ------------------------------------------------------------
    // Sequencer-side outputs
    // ------------------------------------------------------------
    // Write and skip strobes last one cycle after each execution
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_write <= 1'b0;
            skip_next    <= 1'b0;
        end else begin
            result_write <= (state_reg == st_exec) && wb_next;
            skip_next    <= (state_reg == st_exec) && skip_next_val;
        end
    end

    assign result_data  = result_reg;
    assign alu_busy     = (state_reg == st_exec);
    assign status_flags = psw_reg;

endmodule

/* nibble_alu_sva.sv */
// Property checker for the nibble ALU flag behaviour
`timescale 1ns/1ns
module nibble_alu_sva (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // Sequencer side
    input wire logic [3:0]  result_data,
    input wire logic        result_write,
    input wire logic        alu_busy,
    input wire logic [3:0]  status_flags
);
    logic [3:0] op_q;
    logic [3:0] a_q;
    logic [4:0] rot_src;
    logic       ar;
    // --------------------------------------------------------
    // Instruction in flight, seen on the bus
    // --------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q <= 4'hf;
            a_q  <= 4'h0;
        end else if (psel && penable && pwrite && paddr == nibble_alu_pkg::instr_addr) begin
            op_q <= pwdata[3:0];
            a_q  <= pwdata[7:4];
        end
    end
    // Arithmetic execute cycle, rotate source
    assign ar      = alu_busy && op_q < 4'h4;
    assign rot_src = {status_flags[1], a_q};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    hold_nowb_a: assert property (ar && status_flags[2] |=> !result_write)
        else $error("write-back under hold");
    arith_wb_a: assert property (ar && !status_flags[2] |=> result_write)
        else $error("missing write-back");
    zero_res_a: assert property (ar && !status_flags[2] |=> status_flags[0] == (result_data == 4'h0))
        else $error("zero flag wrong");
    hold_zero_a: assert property (ar && status_flags[2] && !status_flags[0] |=> !status_flags[0])
        else $error("zero set under hold");
    logic_keep_a: assert property (alu_busy && op_q inside {[4'h4:4'h6]} |=> $stable(status_flags))
        else $error("logic op moved flags");
    test_clear_a: assert property (alu_busy && op_q inside {4'h7, 4'h8} |=> status_flags[2:0] == {1'b0, $past(status_flags[1:0])})
        else $error("bit test flags wrong");
    cmp_nowb_a: assert property (alu_busy && op_q inside {[4'h9:4'hc]} |=> !result_write && $stable(status_flags))
        else $error("compare changed state");
    rot_move_a: assert property (alu_busy && op_q == 4'hd |=> {result_data, status_flags[1]} == $past(rot_src))
        else $error("rotate wrong");
    reset_flags_a: assert property ($rose(presetn) |-> status_flags == 4'h0)
        else $error("flags not cleared");
    bad_addr_a: assert property (psel && penable && paddr > 8'h0c |-> pslverr)
        else $error("unmapped not refused");
    cover property (ar && status_flags[2]);
    cover property (ar && status_flags[3]);
    cover property (alu_busy && op_q == 4'hd);
endmodule
bind nibble_alu nibble_alu_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .result_data(result_data), .result_write(result_write), .alu_busy(alu_busy),
    .status_flags(status_flags));

/* seq_model.sv */
// Sequencer-side model: destination register and skip counter
`timescale 1ns/1ns
module seq_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Results from the ALU
    input  wire logic [3:0] result_data,
    input  wire logic       result_write,
    input  wire logic       skip_next,
    // Observed state
    output logic [3:0]      gen_reg,
    output int              skip_cnt
);
    // Destination takes a result only when told, skips are only counted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_reg  <= 4'h0;
            skip_cnt <= 0;
        end else begin
            if (result_write) gen_reg <= result_data;
            if (skip_next) skip_cnt <= skip_cnt + 1;
        end
    end
endmodule

/* tb.sv */
// Self-checking bench for the nibble ALU
`timescale 1ns/1ns
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
    logic        result_write, skip_next, alu_busy;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  result_data, status_flags, gen_reg, fl, op, a, b, last_wb;
    logic [10:0] nt, sn;
    logic [10:0] exp_q[$];
    int          err_total, checks_done, skips, skip_cnt;
    nibble_alu i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .result_data(result_data), .result_write(result_write),
        .skip_next(skip_next), .alu_busy(alu_busy), .status_flags(status_flags));
    seq_model i_seq (.pclk(pclk), .presetn(presetn), .result_data(result_data),
        .result_write(result_write), .skip_next(skip_next), .gen_reg(gen_reg),
        .skip_cnt(skip_cnt));
    // --------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Held until pready is seen high at a rising edge
    task automatic apb(logic w, logic [7:0] ad, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic finish_test;
        $display("Checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Expected {data care, flags, data, write-back, skip}; decimal overflow via nibble tables
    function automatic logic [10:0] model(logic [3:0] o, logic [3:0] x, logic [3:0] y);
        logic [4:0] v;
        logic [3:0] f, r;
        logic       w, s;
        f = fl;
        r = 4'h0;
        w = 1'b0;
        s = 1'b0;
        if (o < 4'h4) begin
            v = o[1] ? x - y - (o[0] & fl[1]) : x + y + (o[0] & fl[1]);
            r = v[3:0];
            f[1] = v[4];
            if (fl[3] && v >= 5'd10) begin
                f[1] = 1'b1;
                if (!o[1]) r = v < 5'd20 ? 4'(v - 10) : 4'(48'hdcbadcfedcfe >> (4 * (v - 20)));
                else r = v >= 5'd22 ? 4'(v + 10) : 4'(48'hdcfedcfedcfe >> (4 * (v < 16 ? v - 4 : v - 16)));
            end
            w = !fl[2];
            f[0] = r == 4'h0 && (!fl[2] || fl[0]);
        end else case (o)
            4'h4: r = x | y;
            4'h5: r = x & y;
            4'h6: r = x ^ y;
            4'h7: s = (x & y) == y;
            4'h8: s = (x & y) == 4'h0;
            4'h9: s = x == y;
            4'ha: s = x != y;
            4'hb: s = x >= y;
            4'hc: s = x < y;
            4'hd: r = {fl[1], x[3:1]};
            default: r = 4'h0;
        endcase
        if (o == 4'hd) f[1] = x[0];
        if (o == 4'h7 || o == 4'h8) f[2] = 1'b0;
        if (o > 4'h3) w = o < 4'h7 || o == 4'hd;
        return {w, f, r, w, s};
    endfunction
    // --------------------------------------------------------
    // Clock, watchdog and result monitor
    // --------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        #200000;
        err_total++;
        finish_test();
    end
    always @(posedge pclk) begin
        if (alu_busy === 1'b1) begin
            #1;
            nt = exp_q.pop_front();
            sn = {nt[10], status_flags, nt[10] ? result_data : nt[5:2], result_write, skip_next};
            check("exec", sn, nt);
        end
    end
    // --------------------------------------------------------
    // Main sequence: random flags, operands and opcodes
    // --------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        err_total = 0;
        checks_done = 0;
        skips = 0;
        last_wb = 4'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(18327));
        apb(1'b0, nibble_alu_pkg::status_word_addr, 32'h0);
        check("reset flags", rd, 32'h0);
        fl = 4'h0;
        repeat (300) begin
            if ($urandom_range(1) == 1) begin
                fl = 4'($urandom);
                apb(1'b1, nibble_alu_pkg::status_word_addr, {28'h0, fl});
                apb(1'b0, nibble_alu_pkg::status_word_addr, 32'h0);
                check("status word", rd, {28'h0, fl});
            end
            op = 4'($urandom);
            a = 4'($urandom);
            b = 4'($urandom);
            nt = model(op, a, b);
            fl = nt[9:6];
            skips += nt[0];
            if (nt[1]) last_wb = nt[5:2];
            exp_q.push_back(nt);
            apb(1'b1, nibble_alu_pkg::instr_addr, {20'h0, b, a, op});
            apb(1'b0, nibble_alu_pkg::temp_addr, 32'h0);
            check("temps", rd, {24'h0, b, a});
        end
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped err", se, 32'h1);
        check("unmapped data", rd, 32'h0);
        check("pending", exp_q.size(), 0);
        check("skips", skip_cnt, skips);
        check("dest reg", gen_reg, last_wb);
        finish_test();
    end
endmodule
